// *** rtl/seq0_input_select.sv ***
// Sequencer 0 input select register and analog mux selection
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "seq0_sel_cfg.svh"
module seq0_input_select
   import seq0_sel_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic step_start_in,
   input wire logic [2:0] step_slot_in,
   input wire logic conv_busy_in,
   output logic [1:0] analog_input_out,
   output logic [2:0] active_slot_out
);
   logic [31:0] sel_ff;
   logic [31:0] nxt_sel;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] mux_ff;
   logic [2:0] slot_ff;
   logic [1:0] picked;
   wire hit_sel = (addr_in == `SEL_REG_OFFSET);
   wire sel_wr = wr_in && hit_sel;
   wire sel_rd = rd_in && hit_sel;
   wire latch_step = step_start_in && !conv_busy_in;

   // Field n of a register word, n counted from zero
   function automatic input_sel_type field_of(input logic [31:0] word, input slot_idx_type idx);
      field_of = word[`SEL_FIELD_LSB(idx) +: 2];
   endfunction : field_of

   // Named per-slot views of the register, slot1 is the first sample step
   wire [1:0] slot1_input_sel = field_of(sel_ff, 3'h0);
   wire [1:0] slot2_input_sel = field_of(sel_ff, 3'h1);
   wire [1:0] slot3_input_sel = field_of(sel_ff, 3'h2);
   wire [1:0] slot4_input_sel = field_of(sel_ff, 3'h3);
   wire [1:0] slot5_input_sel = field_of(sel_ff, 3'h4);
   wire [1:0] slot6_input_sel = field_of(sel_ff, 3'h5);
   wire [1:0] slot7_input_sel = field_of(sel_ff, 3'h6);
   wire [1:0] slot8_input_sel = field_of(sel_ff, 3'h7);

   // Write of the select register
   sequence seq_sel_write;
      sel_wr;
   endsequence
   // Read of the select register with no write beside it
   sequence seq_sel_read;
      sel_rd && !wr_in;
   endsequence
   // Step accepted, then the conversion runs for two cycles
   sequence seq_step_then_busy;
      latch_step ##1 conv_busy_in [*2];
   endsequence

   // Register write, reserved bits stay zero
   assign nxt_sel = sel_wr ? (wdata_in & `SEL_WRITE_MASK) : sel_ff;
   // Read data, unmapped reads as zero
   assign nxt_rdata = sel_rd ? sel_ff : 32'h0000_0000;

   slot_field_pick u_pick (
      .reg_word_in(sel_ff),
      .slot_in(step_slot_in),
      .field_out(picked)
   );

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sel_ff <= `SEL_RESET;
         rdata_ff <= 32'h0000_0000;
      end else begin
         sel_ff <= nxt_sel;
         rdata_ff <= nxt_rdata;
      end
   end

   // Field captured at step start, held for the conversion
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mux_ff <= 2'h0;
         slot_ff <= 3'h0;
      end else if (latch_step) begin
         mux_ff <= picked;
         slot_ff <= step_slot_in;
      end
   end

   assign rdata_out = rdata_ff;
   assign analog_input_out = mux_ff;
   assign active_slot_out = slot_ff;

   chk_mux_follows_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      latch_step |=> analog_input_out == $past(picked))
      else $error("mux value not taken from slot field");
   chk_mux_held_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (conv_busy_in && $past(conv_busy_in)) |-> $stable(analog_input_out))
      else $error("mux changed during conversion");
   chk_slot8_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h7) |=> analog_input_out == $past(sel_ff[29:28]))
      else $error("slot eight field wrong");
   chk_slot7_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h6) |=> analog_input_out == $past(sel_ff[25:24]))
      else $error("slot seven field wrong");
   chk_slot6_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h5) |=> analog_input_out == $past(sel_ff[21:20]))
      else $error("slot six field wrong");
   chk_slot1_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h0) |=> analog_input_out == $past(sel_ff[1:0]))
      else $error("slot one field wrong");
   chk_reserved_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (sel_ff & ~`SEL_WRITE_MASK) == 32'h0000_0000)
      else $error("reserved bits not zero");
   chk_write_readback: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_sel_write ##1 seq_sel_read |=>
      rdata_out == ($past(wdata_in, 2) & `SEL_WRITE_MASK))
      else $error("readback mismatch");
   chk_reset_zero: assert property (@(posedge clk_in)
      $past(sys_rst_in) |-> (sel_ff == 32'h0000_0000 && analog_input_out == 2'h0))
      else $error("fields not zero after reset");

   // Second step takes the second field
   chk_slot2_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h1) |=> analog_input_out == $past(slot2_input_sel))
      else $error("slot two field wrong");

   // Third step takes the third field
   chk_slot3_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h2) |=> analog_input_out == $past(slot3_input_sel))
      else $error("slot three field wrong");

   // Fourth step takes the fourth field
   chk_slot4_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h3) |=> analog_input_out == $past(slot4_input_sel))
      else $error("slot four field wrong");

   // Fifth step takes the fifth field
   chk_slot5_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && step_slot_in == 3'h4) |=> analog_input_out == $past(slot5_input_sel))
      else $error("slot five field wrong");

   // Eighth field lands from write data bits 29:28
   chk_slot8_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_wr |=> slot8_input_sel == $past(wdata_in[29:28]))
      else $error("slot eight field not written");

   // Seventh field lands from write data bits 25:24
   chk_slot7_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_wr |=> slot7_input_sel == $past(wdata_in[25:24]))
      else $error("slot seven field not written");

   // Sixth field lands from write data bits 21:20
   chk_slot6_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_wr |=> slot6_input_sel == $past(wdata_in[21:20]))
      else $error("slot six field not written");

   // First field lands from write data bits 1:0
   chk_slot1_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_wr |=> slot1_input_sel == $past(wdata_in[1:0]))
      else $error("slot one field not written");

   // Whole write is masked into the register
   chk_masked_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_wr |=> sel_ff == ($past(wdata_in) & `SEL_WRITE_MASK))
      else $error("masked write wrong");

   // Register holds when not written
   chk_reg_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !sel_wr |=> $stable(sel_ff))
      else $error("register changed without write");

   // Read returns the register one cycle later
   chk_read_value: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sel_rd |=> rdata_out == $past(sel_ff))
      else $error("read data wrong");

   // Read data is zero outside a select read
   chk_rdata_idle_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !sel_rd |=> rdata_out == 32'h0000_0000)
      else $error("read data not zero when idle");

   // Field value one drives input one
   chk_pin_number: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (latch_step && picked == 2'h1) |=> analog_input_out == 2'h1)
      else $error("field one did not select input one");

   // Active slot follows the accepted step
   chk_slot_latched: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      latch_step |=> active_slot_out == $past(step_slot_in))
      else $error("active slot not latched");

   // Step start during a conversion is ignored
   chk_busy_ignored: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (step_start_in && conv_busy_in) |=> ($stable(analog_input_out) && $stable(active_slot_out)))
      else $error("step taken while busy");

   // Mux value held between accepted steps
   chk_mux_idle_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !latch_step |=> $stable(analog_input_out))
      else $error("mux moved without a step");

   // Active slot held between accepted steps
   chk_slot_idle_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !latch_step |=> $stable(active_slot_out))
      else $error("active slot moved without a step");

   // Mux stays put through the conversion that follows a step
   chk_hold_through_conv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      seq_step_then_busy |-> $stable(analog_input_out))
      else $error("mux moved during conversion");

   // Slot and read data clear on reset
   chk_slot_reset_zero: assert property (@(posedge clk_in)
      $past(sys_rst_in) |-> (active_slot_out == 3'h0 && rdata_out == 32'h0000_0000))
      else $error("slot or read data not zero after reset");
endmodule : seq0_input_select
`default_nettype wire

// *** rtl/seq0_sel_cfg.svh ***
// Offsets, field positions, reset values for the sequencer 0 input select register
`ifndef SEQ0_SEL_CFG_SVH
`define SEQ0_SEL_CFG_SVH
`define SEL_REG_OFFSET 8'h40
`define STEP_REG_OFFSET 8'h44
`define SEL_RESET 32'h0000_0000
`define SEL_FIELD_LSB(n) (4 * (n))
`define SEL_WRITE_MASK 32'h3333_3333
`define SLOT_COUNT 8
`endif

// *** rtl/seq0_sel_pkg.sv ***
// Types shared by the sequencer 0 input select logic
package seq0_sel_pkg;
   typedef logic [1:0] input_sel_type;
   typedef logic [2:0] slot_idx_type;
endpackage : seq0_sel_pkg

// *** rtl/slot_field_pick.sv ***
// Selects one slot field out of the input select register
`timescale 1ns/1ps
`default_nettype none
`include "seq0_sel_cfg.svh"
module slot_field_pick
   import seq0_sel_pkg::*;
(
   input wire logic [31:0] reg_word_in,
   input wire logic [2:0] slot_in,
   output logic [1:0] field_out
);
   // Field n sits at bits 4n+1:4n
   function automatic logic [1:0] pick_field(input logic [31:0] w, input logic [2:0] s);
      logic [4:0] lsb;
      lsb = {s, 2'b00};
      pick_field = w[lsb +: 2];
   endfunction : pick_field

   assign field_out = pick_field(reg_word_in, slot_in);
endmodule : slot_field_pick
`default_nettype wire

// *** tb/seq0_input_select_tb.sv ***
// Self-checking testbench for the sequencer 0 input select register
`timescale 1ns/1ps
`default_nettype none
`include "seq0_sel_cfg.svh"
module seq0_input_select_tb;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic step_start_in = 1'b0, conv_busy_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0, rdata_out;
   logic [2:0] step_slot_in = 3'h0, active_slot_out;
   logic [1:0] analog_input_out;
   int error_cnt = 0, checked = 0;
   localparam logic [31:0] PAT = 32'hfedc_ba98; // Every field value appears twice, some reserved bits set
   seq0_input_select uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .step_start_in(step_start_in), .step_slot_in(step_slot_in),
      .conv_busy_in(conv_busy_in), .analog_input_out(analog_input_out),
      .active_slot_out(active_slot_out));
   // 40 MHz clock
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   // Compare and count
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Bus and step drivers
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
      @(posedge clk_in) wr_in <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
      @(posedge clk_in) rd_in <= 1'b0;
      #1 cmp(rdata_out, exp);
   endtask : bus_rd
   task automatic step(input logic [2:0] s, input logic [1:0] exp, input logic [2:0] exp_slot);
      @(posedge clk_in) {step_start_in, step_slot_in} <= {1'b1, s};
      @(posedge clk_in) step_start_in <= 1'b0;
      #1 cmp({30'h0, analog_input_out}, {30'h0, exp});
      cmp({29'h0, active_slot_out}, {29'h0, exp_slot});
   endtask : step
   // Scenarios
   task automatic test_slots();
      bus_wr(`SEL_REG_OFFSET, PAT);
      bus_rd(`SEL_REG_OFFSET, PAT & 32'h3333_3333);
      for (int n = 0; n < 8; n++) step(n[2:0], PAT[4*n +: 2], n[2:0]);
      $display("slot select test done");
   endtask : test_slots
   task automatic test_busy_unmapped();
      @(posedge clk_in) conv_busy_in <= 1'b1;
      step(3'h0, PAT[29:28], 3'h7);
      @(posedge clk_in) conv_busy_in <= 1'b0;
      bus_wr(8'h44, 32'h0);
      bus_rd(8'h44, 32'h0);
      bus_rd(`SEL_REG_OFFSET, PAT & 32'h3333_3333);
      $display("busy and unmapped test done");
   endtask : test_busy_unmapped
   task automatic test_reset();
      @(posedge clk_in) sys_rst_in <= 1'b1;
      @(posedge clk_in) sys_rst_in <= 1'b0;
      #1 cmp({30'h0, analog_input_out}, 32'h0);
      cmp({29'h0, active_slot_out}, 32'h0);
      bus_rd(`SEL_REG_OFFSET, `SEL_RESET);
      step(3'h7, 2'h0, 3'h7);
      $display("reset test done");
   endtask : test_reset
   task automatic complete_run();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      bus_rd(`SEL_REG_OFFSET, `SEL_RESET);
      test_slots();
      test_busy_unmapped();
      test_reset();
      complete_run();
   end
   // Watchdog
   initial begin
      #20000;
      error_cnt++;
      complete_run();
   end
endmodule : seq0_input_select_tb
`default_nettype wire
